// ### pic_cfg.svh
// Register offsets, field positions, codes and vector constants of the interrupt controller
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH
`define PIC_ADDR_W        8
`define PIC_OFS_IE0       8'h00
`define PIC_OFS_IE1       8'h04
`define PIC_OFS_IE2       8'h08
`define PIC_OFS_IP0       8'h0c
`define PIC_OFS_IP1       8'h10
`define PIC_OFS_IP2       8'h14
`define PIC_OFS_IP3       8'h18
`define PIC_OFS_TRIG      8'h1c
`define PIC_OFS_EXT_FLAG  8'h20
`define PIC_OFS_EXT_EN    8'h24
`define PIC_OFS_STATE     8'h28
`define PIC_OFS_EVT_STAT  8'h2c
`define PIC_OFS_EVT_MASK  8'h30
`define PIC_IE0_GLOBAL    7
`define PIC_RST_BYTE      8'h00
`define PIC_RST_WORD      32'h0000_0000
`define PIC_RST_HALF      16'h0000
`define PIC_VEC_BASE      16'h0003
`define PIC_VEC_STEP      16'h0008
`define PIC_VEC_GAP_IDX   4'hd
`define PIC_SRC_EXT0      4'h0
`define PIC_SRC_EXT1      4'h2
`define PIC_SRC_GRP_LO    14
`define PIC_SRC_GRP_HI    15
`define PIC_GRP_LO_MASK   16'h00fc
`define PIC_GRP_HI_MASK   16'hfe00
`define PIC_EXT_SW_MASK   16'hfffc
`define PIC_LVL_TOP       2'h3
`define PIC_EVT_TAKE      0
`define PIC_EVT_EXIT      1
`define PIC_EVT_BAD_EXIT  2
`endif

// ### pic_core_model.sv
// Behavioural processor core that answers the interrupt controller
`timescale 1ns/1ps
module pic_core_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Bench commands
  input  wire logic        busy,
  input  wire logic        exit_req,
  // Controller side
  input  wire logic        vector_take,
  input  wire logic [15:0] vector_addr,
  output logic             instr_boundary,
  output logic             isr_exit_instr,
  output logic [15:0]      pc_q
);
  logic [15:0] stack_q[$];
  // No boundary while an exit executes, but a take accepted in the cycle before still lands with the exit and swallows it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_boundary <= 1'b0;
      isr_exit_instr <= 1'b0;
    end else begin
      instr_boundary <= !busy && !exit_req;
      isr_exit_instr <= exit_req;
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= 16'h0100;
    end else if (vector_take === 1'b1) begin
      stack_q.push_back(pc_q);
      pc_q <= vector_addr;
    end else if (isr_exit_instr === 1'b1 && stack_q.size() > 0) begin
      pc_q <= stack_q.pop_back();
    end
  end
endmodule // pic_core_model

// ### pic_ext_trigger.sv
// Synchroniser and trigger detector for one external interrupt input
`timescale 1ns/1ps
module pic_ext_trigger
  import pic_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  // Pin and mode
  input  wire logic pin,
  input  pic_trig_e mode,
  // Trigger seen
  output logic      hit
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else if (clk_en) begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  always_comb begin
    hit = 1'b0;
    unique case (mode)
      PIC_TRIG_RISE: hit = sync_q & ~prev_q;
      PIC_TRIG_FALL: hit = ~sync_q & prev_q;
      PIC_TRIG_BOTH: hit = sync_q ^ prev_q;
      PIC_TRIG_LOW:  hit = ~sync_q;
    endcase
  end
endmodule // pic_ext_trigger

// ### pic_pkg.sv
// Types shared by the interrupt controller modules
package pic_pkg;
  typedef enum logic [1:0] {
    PIC_TRIG_RISE = 2'b00,
    PIC_TRIG_FALL = 2'b01,
    PIC_TRIG_BOTH = 2'b10,
    PIC_TRIG_LOW  = 2'b11
  } pic_trig_e;
  typedef logic [1:0] pic_level_t;
  typedef logic [3:0] pic_idx_t;
endpackage

// ### pic_prio_select.sv
// Picks the highest level request, ties going to the lowest polling position
`timescale 1ns/1ps
module pic_prio_select
  import pic_pkg::*;
(
  // Requests and their levels
  input  wire logic [15:0] req,
  input  wire logic [31:0] prio,
  // Winner
  output logic             sel_valid,
  output pic_idx_t         sel_idx,
  output pic_level_t       sel_level
);
  always_comb begin
    sel_valid = 1'b0;
    sel_idx   = '0;
    sel_level = '0;
    for (int i = 0; i < 16; i++) begin
      if (req[i] && (!sel_valid || prio[2*i +: 2] > sel_level)) begin
        sel_valid = 1'b1;
        sel_idx   = 4'(i);
        sel_level = prio[2*i +: 2];
      end
    end
  end
endmodule // pic_prio_select

// ### pic_top.sv
// Prioritised 16-source interrupt controller with APB registers and core vector handshake
// Behaviour
// RULE1: On acceptance core pushes PC, then loads source vector 0003h to 0083h.
// RULE2: Service needs source flag, its enable, and the global enable all set.
// RULE3: Each source has a 2-bit level, 00 lowest up to 11 highest.
// RULE4: During service only strictly higher levels are accepted; others stay pending.
// RULE5: While level 3 is in service nothing else is accepted.
// RULE6: Among pending requests of different levels the higher level wins.
// RULE7: Equal levels resolve by fixed polling order, external 0 first, group last.
// RULE8: Vectoring waits for instruction end, then pushes PC, blocks level, loads vector.
// RULE9: Interrupt exit pops PC and clears the active level's in-service state.
// RULE10: Subroutine return leaves in-service state untouched; handlers must use interrupt exit.
// RULE11: External 0 and 1 own vectors; others share two group vectors. External 8 is in neither group mask here.
// RULE12: Each external input has rising, falling, both-edge or low-level trigger.
// RULE13: Entry clears external 0 and 1 flags; software clears flags 2 to 15.
// RULE14: An external request still held after service raises a new interrupt.
// RULE15: Low-level source holds its input until registered, two clocks.
// RULE16: Falling-edge wake needs pin held high and both enables set beforehand.
// RULE17: First priority register: timer1 7-6, ext1 5-4, timer0 3-2, ext0 1-0.
// RULE18: Global enable is bit 7 of first enable register, reset to 0.
// RULE19: One in-service bit per level; exit clears highest; highest sets threshold.
`timescale 1ns/1ps
`include "pic_cfg.svh"
module pic_top
  import pic_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // External pins and on-chip flags
  input  wire logic [15:0] ext_pin,
  input  wire logic [15:0] src_flag,
  // Processor core
  input  wire logic        instr_boundary,
  input  wire logic        isr_exit_instr,
  input  wire logic        subroutine_exit_instr,
  output logic             vector_take,
  output logic [15:0]      vector_addr,
  output logic [3:0]       in_service,
  // Event interrupt
  output logic             irq_out
);
  logic [7:0]  ie0_q;
  logic [7:0]  ie1_q;
  logic [7:0]  ie2_q;
  logic [31:0] prio_q;
  logic [31:0] trig_q;
  logic [15:0] ext_en_q;
  logic [15:0] ext_flag_q;
  logic [15:0] ext_hit;
  logic [3:0]  isv_q;
  logic [2:0]  evt_q;
  logic [2:0]  evt_mask_q;
  logic        take_q;
  logic [15:0] vec_q;
  logic [31:0] rdata_q;
  logic [15:0] src_en;
  logic [15:0] req;
  logic        sel_valid;
  pic_idx_t    sel_idx;
  pic_level_t  sel_level;
  pic_level_t  isv_top;
  logic        accept;
  logic        do_exit;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic [15:0] ext_sw_clr;

  // APB: zero wait states, read data latched in the setup cycle, write data taken in the access cycle
  assign wr      = psel & penable & pwrite & clk_en;
  assign rd      = psel & penable & ~pwrite & clk_en;
  assign pready  = 1'b1;
  assign prdata  = rdata_q;
  assign mapped  = (paddr <= `PIC_OFS_EVT_MASK) && (paddr[1:0] == 2'b00);
  assign pslverr = psel & penable & ~mapped;

  // Trigger detectors, one per external input
  for (genvar g = 0; g < 16; g++) begin : g_ext
    pic_ext_trigger u_trig (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_en  (clk_en),
      .pin     (ext_pin[g]),
      .mode    (pic_trig_e'(trig_q[2*g +: 2])),
      .hit     (ext_hit[g])
    ); // RULE12
  end

  // Per-source enables in polling order
  assign src_en = {ie1_q[6], ie1_q[5], ie1_q[4], ie1_q[2], ie2_q[2], ie2_q[1], ie1_q[1],
                   ie1_q[0], ie0_q[6], ie2_q[0], ie0_q[5], ie0_q[4], ie0_q[3], ie0_q[2],
                   ie0_q[1], ie0_q[0]};

  // Request vector: ext 0/1 own slots, 2-7 and 9-15 share group slots
  always_comb begin
    req = src_flag; // RULE11
    req[`PIC_SRC_EXT0] = ext_flag_q[0];
    req[`PIC_SRC_EXT1] = ext_flag_q[1];
    req[`PIC_SRC_GRP_LO] = |(ext_flag_q & ext_en_q & `PIC_GRP_LO_MASK);
    req[`PIC_SRC_GRP_HI] = |(ext_flag_q & ext_en_q & `PIC_GRP_HI_MASK);
    req = req & src_en & {16{ie0_q[`PIC_IE0_GLOBAL]}}; // RULE2
  end

  pic_prio_select u_sel (
    .req       (req),
    .prio      (prio_q),
    .sel_valid (sel_valid),
    .sel_idx   (sel_idx),
    .sel_level (sel_level)
  ); // RULE3 RULE6 RULE7

  // Highest level now in service
  always_comb begin
    isv_top = '0;
    for (int l = 0; l < 4; l++) begin
      if (isv_q[l]) begin
        isv_top = 2'(l); // RULE19
      end
    end
  end

  // Strictly higher than the active level; a level 3 service blocks all
  assign accept  = instr_boundary & sel_valid & (~|isv_q | (sel_level > isv_top)); // RULE4 RULE5 RULE8
  assign do_exit = isr_exit_instr & |isv_q;

  // In-service bits: set on take, highest cleared on exit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      isv_q <= '0;
    end else if (clk_en) begin
      // An exit is never lost, even when a new take lands in the same cycle
      if (do_exit) begin
        isv_q[isv_top] <= 1'b0; // RULE9 RULE10 RULE19
      end
      if (accept) begin
        isv_q[sel_level] <= 1'b1; // RULE8
      end
    end
  end

  // Vector handshake to core: one-cycle pulse, core pushes PC then jumps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      take_q <= 1'b0;
      vec_q  <= `PIC_RST_HALF;
    end else if (clk_en) begin
      take_q <= accept; // RULE1
      if (accept) begin
        vec_q <= `PIC_VEC_BASE + `PIC_VEC_STEP *
                 ((sel_idx < `PIC_VEC_GAP_IDX) ? {12'h000, sel_idx} : {12'h000, sel_idx} + 16'h0001);
      end
    end
  end
  assign vector_take = take_q;
  assign vector_addr = vec_q;
  assign in_service  = isv_q;

  // Software clears only flags 2 to 15
  assign ext_sw_clr = (wr && paddr == `PIC_OFS_EXT_FLAG) ? (pwdata[15:0] & `PIC_EXT_SW_MASK)
                                                        : `PIC_RST_HALF;

  // External flags: hit wins over any clear; held level re-raises after service
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_flag_q <= `PIC_RST_HALF;
    end else if (clk_en) begin
      for (int i = 0; i < 16; i++) begin
        if (ext_hit[i]) begin
          ext_flag_q[i] <= 1'b1; // RULE14 RULE15
        end else if (accept && ((i == 0 && sel_idx == `PIC_SRC_EXT0) ||
                                (i == 1 && sel_idx == `PIC_SRC_EXT1))) begin
          ext_flag_q[i] <= 1'b0; // RULE13
        end else if (ext_sw_clr[i]) begin
          ext_flag_q[i] <= 1'b0; // RULE13
        end
      end
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie0_q    <= `PIC_RST_BYTE; // RULE18
      ie1_q    <= `PIC_RST_BYTE;
      ie2_q    <= `PIC_RST_BYTE;
      prio_q   <= `PIC_RST_WORD;
      trig_q   <= `PIC_RST_WORD;
      ext_en_q <= `PIC_RST_HALF;
      evt_mask_q <= '0;
    end else if (wr) begin
      unique case (paddr)
        `PIC_OFS_IE0:      ie0_q    <= pwdata[7:0]; // RULE18
        `PIC_OFS_IE1:      ie1_q    <= pwdata[7:0] & 8'h77;
        `PIC_OFS_IE2:      ie2_q    <= pwdata[7:0] & 8'h07;
        `PIC_OFS_IP0:      prio_q[7:0]   <= pwdata[7:0]; // RULE17
        `PIC_OFS_IP1:      prio_q[15:8]  <= pwdata[7:0];
        `PIC_OFS_IP2:      prio_q[23:16] <= pwdata[7:0];
        `PIC_OFS_IP3:      prio_q[31:24] <= pwdata[7:0];
        `PIC_OFS_TRIG:     trig_q   <= pwdata;
        `PIC_OFS_EXT_EN:   ext_en_q <= pwdata[15:0];
        `PIC_OFS_EVT_MASK: evt_mask_q <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // Event status: set wins over read-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_q <= '0;
    end else if (clk_en) begin
      // Clear only what the setup cycle captured, so a later event is not lost
      evt_q <= ((rd && paddr == `PIC_OFS_EVT_STAT) ? (evt_q & ~rdata_q[2:0]) : evt_q) |
               {isr_exit_instr & ~|isv_q, do_exit, accept};
    end
  end
  assign irq_out = |(evt_q & evt_mask_q);

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= `PIC_RST_WORD;
    end else if (clk_en && psel && !penable) begin
      unique case (paddr)
        `PIC_OFS_IE0:      rdata_q <= {24'h0, ie0_q};
        `PIC_OFS_IE1:      rdata_q <= {24'h0, ie1_q};
        `PIC_OFS_IE2:      rdata_q <= {24'h0, ie2_q};
        `PIC_OFS_IP0:      rdata_q <= {24'h0, prio_q[7:0]};
        `PIC_OFS_IP1:      rdata_q <= {24'h0, prio_q[15:8]};
        `PIC_OFS_IP2:      rdata_q <= {24'h0, prio_q[23:16]};
        `PIC_OFS_IP3:      rdata_q <= {24'h0, prio_q[31:24]};
        `PIC_OFS_TRIG:     rdata_q <= trig_q;
        `PIC_OFS_EXT_FLAG: rdata_q <= {16'h0, ext_flag_q};
        `PIC_OFS_EXT_EN:   rdata_q <= {16'h0, ext_en_q};
        `PIC_OFS_STATE:    rdata_q <= {19'h0, sel_valid, sel_idx, sel_level, isv_top, isv_q};
        `PIC_OFS_EVT_STAT: rdata_q <= {29'h0, evt_q};
        `PIC_OFS_EVT_MASK: rdata_q <= {29'h0, evt_mask_q};
        default:           rdata_q <= `PIC_RST_WORD;
      endcase
    end
  end

  // Helper copies for checks
  logic       chk_glob_q;
  logic       chk_bnd_q;
  logic [3:0] chk_isv_q;
  pic_level_t chk_lvl_q;
  pic_idx_t   chk_idx_q;
  logic       chk_hit0_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_glob_q <= 1'b0;
      chk_bnd_q  <= 1'b0;
      chk_isv_q  <= '0;
      chk_lvl_q  <= '0;
      chk_idx_q  <= '0;
      chk_hit0_q <= 1'b0;
    end else if (clk_en) begin
      chk_glob_q <= ie0_q[`PIC_IE0_GLOBAL];
      chk_bnd_q  <= instr_boundary;
      chk_isv_q  <= isv_q;
      chk_lvl_q  <= sel_level;
      chk_idx_q  <= sel_idx;
      chk_hit0_q <= ext_hit[0];
    end
  end

  a_global_gate: assert property (@(posedge pclk) disable iff (!presetn)
    vector_take |-> chk_glob_q) else $error("vector taken with global enable off"); // RULE2
  a_vector_range: assert property (@(posedge pclk) disable iff (!presetn)
    vector_take |-> (vector_addr >= 16'h0003 && vector_addr <= 16'h0083 &&
                     vector_addr[2:0] == 3'h3)) else $error("vector out of range"); // RULE1
  a_take_boundary: assert property (@(posedge pclk) disable iff (!presetn)
    vector_take |-> chk_bnd_q) else $error("vector taken mid-instruction"); // RULE8
  a_strict_nest: assert property (@(posedge pclk) disable iff (!presetn)
    vector_take && chk_isv_q != 4'h0 |-> !chk_isv_q[3] &&
    (!chk_isv_q[2] || chk_lvl_q == 2'h3) && (!chk_isv_q[1] || chk_lvl_q >= 2'h2) &&
    (!chk_isv_q[0] || chk_lvl_q != 2'h0))
    else $error("nested take not higher"); // RULE4
  a_top_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    vector_take |-> !chk_isv_q[3]) else $error("take while level 3 in service"); // RULE5
  a_level_marked: assert property (@(posedge pclk) disable iff (!presetn)
    vector_take |-> in_service[chk_lvl_q]) else $error("taken level not in service"); // RULE8
  a_exit_clears: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && do_exit && !accept |=> in_service == ($past(isv_q) & ~(4'h1 << $past(isv_top))))
    else $error("exit did not clear top level"); // RULE9
  a_ret_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && subroutine_exit_instr && !isr_exit_instr && !accept |=> $stable(in_service))
    else $error("subroutine return changed service state"); // RULE10
  a_ext0_clear: assert property (@(posedge pclk) disable iff (!presetn)
    vector_take && chk_idx_q == `PIC_SRC_EXT0 && !chk_hit0_q |-> !ext_flag_q[0])
    else $error("ext0 flag not cleared on entry"); // RULE13
  a_group_vector: assert property (@(posedge pclk) disable iff (!presetn)
    vector_take && chk_idx_q == 4'hf |-> vector_addr == 16'h0083)
    else $error("last group vector wrong"); // RULE11

  c_nested: cover property (@(posedge pclk) disable iff (!presetn)
    vector_take && chk_isv_q != 4'h0);
  c_exit: cover property (@(posedge pclk) disable iff (!presetn) clk_en && do_exit);
  c_top_level: cover property (@(posedge pclk) disable iff (!presetn) isv_q[3]);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq_out);
endmodule // pic_top

// ### testbench.sv
// Self-checking bench for the prioritised interrupt controller
`timescale 1ns/1ps
module testbench;
  logic        pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        busy = 1'b0, exit_req = 1'b0, sub_exit = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic        pready, pslverr, err_q, instr_boundary, isr_exit_instr, vector_take, irq_out;
  logic [15:0] ext_pin = 16'h0, src_flag = 16'h0, vector_addr, pc_q, last_vec;
  logic [3:0]  in_service;
  int          mismatches = 0, compares = 0, takes = 0;

  pic_top i_pic_top (
    .pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_pin, .src_flag, .instr_boundary, .isr_exit_instr,
    .subroutine_exit_instr(sub_exit), .vector_take, .vector_addr, .in_service, .irq_out
  );
  pic_core_model i_pic_core_model (
    .pclk, .presetn, .busy, .exit_req, .vector_take, .vector_addr, .instr_boundary,
    .isr_exit_instr, .pc_q
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (vector_take === 1'b1) begin
      takes++;
      last_vec = vector_addr;
    end
  end

  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q  = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic exp_take(input logic [15:0] v);
    int n;
    n = takes;
    repeat (40) if (takes == n) @(posedge pclk);
    @(posedge pclk);
    chk("take", takes - n, 1);
    chk("vector", last_vec, v);
  endtask
  task automatic exp_none(input int k);
    int n;
    n = takes;
    repeat (k) @(posedge pclk);
    chk("no take", takes - n, 0);
  endtask
  task automatic isr_exit;
    @(posedge pclk) exit_req <= 1'b1;
    @(posedge pclk) exit_req <= 1'b0;
    @(posedge pclk);
  endtask
  // Hold the core busy so all flags are pending at the same boundary
  task automatic arm(input logic [15:0] f);
    busy <= 1'b1;
    repeat (2) @(posedge pclk);
    src_flag <= f;
    @(posedge pclk);
    busy <= 1'b0;
  endtask

  task automatic t_reset;
    apb(0, 8'h00, 0);
    chk("enable0", rd_q, 32'h0);
    apb(0, 8'h0c, 0);
    chk("prio0", rd_q, 32'h0);
    apb(1, 8'h34, 32'hff);
    chk("unmapped", err_q, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_gate;
    src_flag <= 16'h0002;
    apb(1, 8'h00, 32'h02);
    exp_none(20);
    busy <= 1'b1;
    apb(1, 8'h00, 32'h82);
    exp_none(10);
    busy <= 1'b0;
    exp_take(16'h000b);
    chk("pc", pc_q, 16'h000b);
    chk("in_service", in_service, 4'b0001);
    src_flag <= 16'h0;
    isr_exit;
    exp_none(5);
    chk("in_service", in_service, 4'b0000);
    chk("pc", pc_q, 16'h0100);
    $display("test gate done");
  endtask
  task automatic t_nest;
    apb(1, 8'h0c, 32'h44);
    apb(1, 8'h18, 32'h08);
    apb(1, 8'h00, 32'h8a);
    apb(1, 8'h04, 32'h10);
    src_flag <= 16'h0002;
    exp_take(16'h000b);
    src_flag <= 16'h0008;
    exp_none(20);
    src_flag <= 16'h2008;
    exp_take(16'h0073);
    chk("in_service", in_service, 4'b0110);
    src_flag <= 16'h0008;
    isr_exit;
    exp_none(10);
    chk("in_service", in_service, 4'b0010);
    isr_exit;
    exp_take(16'h001b);
    src_flag <= 16'h0;
    isr_exit;
    $display("test nest done");
  endtask
  task automatic t_top;
    apb(1, 8'h0c, 32'h0c);
    apb(1, 8'h18, 32'h0c);
    src_flag <= 16'h0002;
    exp_take(16'h000b);
    chk("in_service", in_service, 4'b1000);
    src_flag <= 16'h2000;
    exp_none(20);
    sub_exit <= 1'b1;
    @(posedge pclk) sub_exit <= 1'b0;
    exp_none(5);
    chk("in_service", in_service, 4'b1000);
    isr_exit;
    exp_take(16'h0073);
    src_flag <= 16'h0;
    isr_exit;
    $display("test top done");
  endtask
  task automatic t_order;
    apb(1, 8'h18, 32'h0);
    apb(1, 8'h0c, 32'h0);
    arm(16'h000a);
    exp_take(16'h000b);
    src_flag <= 16'h0008;
    isr_exit;
    exp_take(16'h001b);
    src_flag <= 16'h0;
    isr_exit;
    apb(1, 8'h0c, 32'h80);
    arm(16'h000a);
    exp_take(16'h001b);
    src_flag <= 16'h0;
    isr_exit;
    isr_exit;
    $display("test order done");
  endtask
  task automatic t_ext;
    logic [1:0] m;
    apb(1, 8'h0c, 32'h0);
    apb(1, 8'h00, 32'h81);
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      ext_pin[0] <= m[0];
      apb(1, 8'h1c, {30'h0, m});
      repeat (10) @(posedge pclk);
      while (in_service !== 4'h0) isr_exit;
      ext_pin[0] <= ~m[0];
      exp_take(16'h0003);
      apb(0, 8'h20, 0);
      chk("ext0 flag", rd_q[0], m == 2'b11);
      isr_exit;
      if (m == 2'b11) exp_take(16'h0003);
      ext_pin[0] <= m[0];
      isr_exit;
    end
    repeat (10) @(posedge pclk);
    while (in_service !== 4'h0) isr_exit;
    $display("test ext done");
  endtask
  task automatic t_group;
    apb(1, 8'h24, 32'h0208);
    apb(1, 8'h04, 32'h60);
    ext_pin <= ext_pin | 16'h0208;
    exp_take(16'h007b);
    apb(0, 8'h20, 0);
    chk("group flag", rd_q[3], 1'b1);
    apb(1, 8'h20, 32'h08);
    isr_exit;
    exp_take(16'h0083);
    apb(1, 8'h20, 32'h0200);
    apb(0, 8'h20, 0);
    chk("ext flags", rd_q, 32'h0);
    isr_exit;
    $display("test group done");
  endtask
  task automatic t_irq;
    apb(0, 8'h2c, 0);
    apb(1, 8'h30, 32'h04);
    isr_exit;
    repeat (2) @(posedge pclk);
    chk("irq", irq_out, 1'b1);
    apb(0, 8'h2c, 0);
    chk("status", rd_q, 32'h04);
    repeat (2) @(posedge pclk);
    chk("irq", irq_out, 1'b0);
    apb(1, 8'h30, 32'h0);
    isr_exit;
    repeat (2) @(posedge pclk);
    chk("irq masked", irq_out, 1'b0);
    apb(0, 8'h2c, 0);
    chk("status", rd_q, 32'h04);
    $display("test irq done");
  endtask

  initial begin
    #400000;
    mismatches++;
    end_sim;
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_gate;
    t_nest;
    t_top;
    t_order;
    t_ext;
    t_group;
    t_irq;
    end_sim;
  end
endmodule // testbench
